// ---- bench/cscp_audio_model.sv ----
// audio module stand-in: switching timing and latch clear for the output stage
`timescale 1ns/1ps

module cscp_audio_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear_req,
	output logic [1:0] pwm_timing,
	output logic latch_clear
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic req_reg;

	////////////////////////////////////////////////////////////////////////////////
	// 57 cycles at 20 MHz is about 350.9 kHz, inside the one percent band
	always_comb begin
		cnt_next = (cnt_reg == 8'h38) ? 8'h00 : cnt_reg + 8'h01;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			req_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			req_reg <= clear_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bridge-tied halves switch in opposition
	assign pwm_timing[0] = (cnt_reg < 8'h1C);
	assign pwm_timing[1] = ~pwm_timing[0];
	// one-cycle clear pulse, no register write involved
	assign latch_clear = clear_req & ~req_reg;
endmodule : cscp_audio_model

// ---- bench/cscp_top_bench.sv ----
// self-checking bench for the class d stage control and protection block
`timescale 1ns/1ps

module cscp_top_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] i2c_page = 8'h00;
	logic [7:0] i2c_ofs = 8'h00;
	logic i2c_wr = 1'b0;
	logic i2c_rd = 1'b0;
	logic [7:0] i2c_wdata = 8'h00;
	logic [7:0] i2c_rdata;
	logic [15:0] uc_addr = 16'h0000;
	logic uc_wr = 1'b0;
	logic uc_rd = 1'b0;
	logic [7:0] uc_wdata = 8'h00;
	logic [7:0] uc_rdata;
	logic [1:0] pwm_timing;
	logic [1:0] short_sense = 2'h0;
	logic latch_clear;
	logic clear_req = 1'b0;
	cscp_pkg::cscp_gate_t [1:0] gate_drive;
	cscp_pkg::cscp_trip_t [1:0] short_trip_level;
	logic [1:0] fault;
	logic pwm_rate_ok;
	int err_total = 0;
	int n_compared = 0;
	logic [7:0] rv;

	always #25 clk = ~clk;

	cscp_top i_dut (.clk(clk), .rst(rst), .i2c_page(i2c_page), .i2c_ofs(i2c_ofs),
		.i2c_wr(i2c_wr), .i2c_rd(i2c_rd), .i2c_wdata(i2c_wdata), .i2c_rdata(i2c_rdata),
		.uc_addr(uc_addr), .uc_wr(uc_wr), .uc_rd(uc_rd), .uc_wdata(uc_wdata),
		.uc_rdata(uc_rdata), .pwm_timing(pwm_timing), .short_sense(short_sense),
		.latch_clear(latch_clear), .gate_drive(gate_drive),
		.short_trip_level(short_trip_level), .fault(fault), .pwm_rate_ok(pwm_rate_ok));

	cscp_audio_model i_audio (.clk(clk), .rst(rst), .clear_req(clear_req),
		.pwm_timing(pwm_timing), .latch_clear(latch_clear));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	// one register access on either port; read data settles one edge later
	task automatic acc(input logic uc, input logic wr, input logic [7:0] ofs,
			input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk);
		if (uc) begin
			uc_addr <= {8'hA0, ofs};
			uc_wdata <= wd;
			uc_wr <= wr;
			uc_rd <= ~wr;
		end else begin
			i2c_ofs <= ofs;
			i2c_wdata <= wd;
			i2c_wr <= wr;
			i2c_rd <= ~wr;
		end
		@(posedge clk);
		uc_wr <= 1'b0;
		uc_rd <= 1'b0;
		i2c_wr <= 1'b0;
		i2c_rd <= 1'b0;
		#1;
		rd = uc ? uc_rdata : i2c_rdata;
	endtask : acc

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	////////////////////////////////////////////////////////////////////////////////
	task automatic reset_values;
		chk({6'h00, gate_drive[0]}, 8'h00);
		chk({6'h00, fault}, 8'h00);
		chk({7'h00, pwm_rate_ok}, 8'h00);
		chk({4'h0, short_trip_level}, 8'h05);
		for (int k = 0; k < 4; k++) begin
			acc(k[1], 1'b0, 8'h8A + 8'(k), 8'h00, rv);
			chk(rv, k[0] ? 8'h00 : 8'h05);
		end
		chk({6'h00, gate_drive[1]}, 8'h00);
	endtask : reset_values

	task automatic trip_codes;
		for (int k = 0; k < 4; k++) begin
			acc(1'b0, 1'b1, 8'h8A, 8'h01 | 8'(k << 2), rv);
			acc(1'b1, 1'b1, 8'h8C, 8'h01 | 8'(k << 2), rv);
			acc(1'b1, 1'b0, 8'h8A, 8'h00, rv);
			chk(rv, 8'h01 | 8'(k << 2));
			acc(1'b0, 1'b0, 8'h8C, 8'h00, rv);
			chk(rv, 8'h01 | 8'(k << 2));
			chk({4'h0, short_trip_level}, 8'(k * 5));
		end
		acc(1'b0, 1'b1, 8'h8A, 8'h85, rv);
		acc(1'b1, 1'b1, 8'h8C, 8'h85, rv);
	endtask : trip_codes

	task automatic oper_masks;
		acc(1'b0, 1'b1, 8'h8B, 8'hFF, rv);
		acc(1'b1, 1'b1, 8'h8D, 8'hFF, rv);
		acc(1'b1, 1'b0, 8'h8B, 8'h00, rv);
		chk(rv, 8'hCF);
		acc(1'b0, 1'b0, 8'h8D, 8'h00, rv);
		chk(rv, 8'hCF);
		acc(1'b0, 1'b1, 8'h8B, 8'h00, rv);
		acc(1'b1, 1'b1, 8'h8D, 8'h00, rv);
	endtask : oper_masks

	// deliberate writes to reserved slots and another page must leave no trace
	task automatic refused_access;
		acc(1'b0, 1'b1, 8'h8E, 8'hAA, rv);
		acc(1'b1, 1'b1, 8'h8F, 8'h55, rv);
		acc(1'b0, 1'b0, 8'h8E, 8'h00, rv);
		chk(rv, 8'h00);
		acc(1'b1, 1'b0, 8'h8F, 8'h00, rv);
		chk(rv, 8'h00);
		@(posedge clk);
		i2c_page <= 8'h01;
		acc(1'b0, 1'b1, 8'h8A, 8'h00, rv);
		@(posedge clk);
		i2c_page <= 8'h00;
		acc(1'b0, 1'b0, 8'h8A, 8'h00, rv);
		chk(rv, 8'h85);
	endtask : refused_access

	task automatic gate_follow;
		logic [1:0] p;
		cyc(1);
		p = pwm_timing;
		repeat (120) begin
			cyc(1);
			chk({6'h00, gate_drive[0]}, {6'h00, p[0], ~p[0]});
			chk({6'h00, gate_drive[1]}, {6'h00, p[1], ~p[1]});
			p = pwm_timing;
		end
		chk({7'h00, pwm_rate_ok}, 8'h01);
	endtask : gate_follow

	task automatic short_latch;
		@(posedge clk);
		short_sense <= 2'b01;
		repeat (8) begin
			cyc(1);
			if (fault[0] === 1'b1) break;
		end
		chk({6'h00, fault}, 8'h01);
		chk({6'h00, gate_drive[0]}, 8'h00);
		@(posedge clk);
		short_sense <= 2'b00;
		cyc(10);
		chk({6'h00, fault}, 8'h01);
		chk({6'h00, gate_drive[1]}, 8'h00);
		acc(1'b1, 1'b0, 8'h8B, 8'h00, rv);
		chk(rv, 8'h10);
		acc(1'b0, 1'b0, 8'h8D, 8'h00, rv);
		chk(rv, 8'h00);
		@(posedge clk);
		clear_req <= 1'b1;
		@(posedge clk);
		clear_req <= 1'b0;
		#1;
		chk({6'h00, fault}, 8'h00);
		cyc(2);
		chk({7'h00, |gate_drive[0]}, 8'h01);
		chk({7'h00, |gate_drive[1]}, 8'h01);
	endtask : short_latch

	task automatic prot_off;
		acc(1'b0, 1'b1, 8'h8B, 8'h40, rv);
		acc(1'b1, 1'b1, 8'h8D, 8'h40, rv);
		@(posedge clk);
		short_sense <= 2'b11;
		cyc(12);
		chk({6'h00, fault}, 8'h00);
		acc(1'b0, 1'b0, 8'h8B, 8'h00, rv);
		chk(rv, 8'h40);
		@(posedge clk);
		short_sense <= 2'b00;
		cyc(6);
		acc(1'b0, 1'b1, 8'h8B, 8'h00, rv);
		acc(1'b1, 1'b1, 8'h8D, 8'h00, rv);
		cyc(4);
		chk({6'h00, fault}, 8'h00);
	endtask : prot_off

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		reset_values();
		trip_codes();
		oper_masks();
		refused_access();
		gate_follow();
		short_latch();
		prot_off();
		complete_run();
	end

	// whole run is about 250 cycles
	initial begin
		#(20000 * 50);
		err_total++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule : cscp_top_bench

// ---- logic/cscp_bridge_guard.sv ----
// short circuit sensing, protection latch and gate drive for one half-bridge
`timescale 1ns/1ps

module cscp_bridge_guard (
	input wire logic clk,
	input wire logic rst,
	input wire logic short_sense,
	input wire logic enable,
	input wire logic protection_off,
	input wire logic latch_clear,
	input wire logic pwm_timing,
	output cscp_pkg::cscp_gate_t gate_drive,
	output logic fault
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchroniser and agreement filter

	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic short_seen_reg;
	logic short_seen_next;

	always_comb begin
		sync_next = {sync_reg[1:0], short_sense};
		short_seen_next = short_seen_reg;
		if (sync_reg[1] == sync_reg[2]) begin
			short_seen_next = sync_reg[2];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_reg <= 3'h0;
			short_seen_reg <= 1'b0;
		end else begin
			sync_reg <= sync_next;
			short_seen_reg <= short_seen_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// protection latch and gate drive

	logic latch_reg;
	logic latch_next;
	logic trip_set;
	logic run;
	cscp_pkg::cscp_gate_t gate_reg;
	cscp_pkg::cscp_gate_t gate_next;

	always_comb begin
		trip_set = short_seen_reg & ~protection_off;
		// a trip in the clearing cycle is kept
		latch_next = trip_set | (latch_reg & ~latch_clear);
		run = enable & ~latch_next;
		gate_next.hi = run & pwm_timing;
		gate_next.lo = run & ~pwm_timing;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_reg <= 1'b0;
			gate_reg <= '0;
		end else begin
			latch_reg <= latch_next;
			gate_reg <= gate_next;
		end
	end

	assign gate_drive = gate_reg;
	assign fault = latch_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	trip_sets_latch_a: assert property (trip_set |=> latch_reg)
		else $error("short with protection on did not latch");
	latched_gates_off_a: assert property (latch_reg |-> !(gate_reg.hi || gate_reg.lo))
		else $error("transistor on while latched");
	clear_releases_a: assert property (latch_clear && !trip_set |=> !latch_reg)
		else $error("latch not released by clear");
	prot_off_holds_a: assert property (!latch_reg && protection_off |=> !latch_reg)
		else $error("latch set while protection off");
	filter_passes_a: assert property (short_sense [*5] ##1 !protection_off |-> short_seen_reg)
		else $error("steady short never seen");
	enabled_follows_a: assert property (enable && !latch_next |=> gate_reg.hi == $past(pwm_timing))
		else $error("gate does not follow timing");

	latch_trip_c: cover property (trip_set ##1 latch_reg);
	latch_clear_c: cover property (latch_reg ##1 latch_clear ##1 !latch_reg);

endmodule : cscp_bridge_guard

// ---- logic/cscp_pkg.sv ----
// constants and types shared by the class d stage control and protection block
package cscp_pkg;

	localparam int BRIDGES = 2;

	// register addressing, page 0 offsets and the microcontroller window
	localparam logic [7:0] REG_PAGE = 8'h00;
	localparam logic [7:0] UC_BASE_HI = 8'hA0;
	localparam logic [7:0] OFS_A_CTRL = 8'h8A;
	localparam logic [7:0] OFS_A_OPER = 8'h8B;
	localparam logic [7:0] OFS_B_CTRL = 8'h8C;
	localparam logic [7:0] OFS_B_OPER = 8'h8D;
	localparam logic [7:0] OFS_RSVD_ONE = 8'h8E;
	localparam logic [7:0] OFS_RSVD_TWO = 8'h8F;

	// field positions
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_TRIP_LSB = 2;
	localparam int OPER_FAULT_BIT = 4;
	localparam int OPER_PROT_OFF_BIT = 6;

	// reset values and writable bits
	localparam logic [7:0] CTRL_RESET = 8'h05;
	localparam logic [7:0] OPER_RESET = 8'h00;
	localparam logic [7:0] OPER_WR_MASK = 8'hCF;
	localparam logic [7:0] READ_NONE = 8'h00;

	// switching rate check
	localparam real CLK_KHZ = 20000.0;
	localparam real PWM_NOM_KHZ = 352.8;
	localparam real PWM_TOL_PCT = 1.0;
	localparam int PWM_MIN_CYC = int'($ceil(CLK_KHZ / (PWM_NOM_KHZ * (1.0 + PWM_TOL_PCT / 100.0))));
	localparam int PWM_MAX_CYC = int'($floor(CLK_KHZ / (PWM_NOM_KHZ * (1.0 - PWM_TOL_PCT / 100.0))));
	localparam int PWM_SLACK_CYC = 1;
	localparam int PWM_CNT_W = 8;

	// short detect level as a fraction of full scale output
	typedef enum logic [1:0] {
		TRIP_10PCT = 2'h0,
		TRIP_14PCT = 2'h1,
		TRIP_16PCT = 2'h2,
		TRIP_20PCT = 2'h3
	} cscp_trip_t;

	// one half-bridge: high side and low side transistor on
	typedef struct packed {
		logic hi;
		logic lo;
	} cscp_gate_t;

	// one normalised register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] ofs;
		logic [7:0] wdata;
	} cscp_acc_t;

	// decoded register slot
	typedef struct packed {
		logic hit;
		logic oper;
		logic idx;
	} cscp_dec_t;

endpackage : cscp_pkg

// ---- logic/cscp_top.sv ----
// register pairs and protection for the two half-bridges of the class d stage
`timescale 1ns/1ps

module cscp_top #(
	parameter int N_BRIDGE = cscp_pkg::BRIDGES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] i2c_page,
	input wire logic [7:0] i2c_ofs,
	input wire logic i2c_wr,
	input wire logic i2c_rd,
	input wire logic [7:0] i2c_wdata,
	output logic [7:0] i2c_rdata,
	input wire logic [15:0] uc_addr,
	input wire logic uc_wr,
	input wire logic uc_rd,
	input wire logic [7:0] uc_wdata,
	output logic [7:0] uc_rdata,
	input wire logic [1:0] pwm_timing,
	input wire logic [1:0] short_sense,
	input wire logic latch_clear,
	output cscp_pkg::cscp_gate_t [1:0] gate_drive,
	output cscp_pkg::cscp_trip_t [1:0] short_trip_level,
	output logic [1:0] fault,
	output logic pwm_rate_ok
);

	////////////////////////////////////////////////////////////////////////////////
	// parameter check

	generate
		if (N_BRIDGE != cscp_pkg::BRIDGES) begin : g_bad_count
			$error("register map serves exactly two half-bridges");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// decoding shared by both access ports

	function automatic cscp_pkg::cscp_dec_t decode(input logic [7:0] ofs);
		cscp_pkg::cscp_dec_t d;
		d = '0;
		unique case (ofs)
			cscp_pkg::OFS_A_CTRL: begin
				d = '{hit: 1'b1, oper: 1'b0, idx: 1'b0};
			end
			cscp_pkg::OFS_B_CTRL: begin
				d = '{hit: 1'b1, oper: 1'b0, idx: 1'b1};
			end
			cscp_pkg::OFS_A_OPER: begin
				d = '{hit: 1'b1, oper: 1'b1, idx: 1'b0};
			end
			cscp_pkg::OFS_B_OPER: begin
				d = '{hit: 1'b1, oper: 1'b1, idx: 1'b1};
			end
			// reserved slots and all else: no storage, read as zero
			default: begin
				d = '0;
			end
		endcase
		return d;
	endfunction : decode

	logic [7:0] ctrl_reg [2];
	logic [7:0] oper_reg [2];
	logic [7:0] ctrl_next [2];
	logic [7:0] oper_next [2];
	logic [1:0] latch_state;

	function automatic logic [7:0] read_byte(input cscp_pkg::cscp_dec_t d,
		input logic [7:0] ctrl_a, input logic [7:0] ctrl_b,
		input logic [7:0] oper_a, input logic [7:0] oper_b, input logic [1:0] flt);
		logic [7:0] v;
		v = cscp_pkg::READ_NONE;
		if (d.hit && !d.oper) begin
			v = d.idx ? ctrl_b : ctrl_a;
		end else if (d.hit) begin
			v = d.idx ? oper_b : oper_a;
			v[cscp_pkg::OPER_FAULT_BIT] = flt[d.idx];
		end
		return v;
	endfunction : read_byte

	////////////////////////////////////////////////////////////////////////////////
	// access ports folded onto one form

	cscp_pkg::cscp_acc_t i2c_acc;
	cscp_pkg::cscp_acc_t uc_acc;
	cscp_pkg::cscp_dec_t i2c_dec;
	cscp_pkg::cscp_dec_t uc_dec;
	logic i2c_here;
	logic uc_here;

	always_comb begin
		i2c_here = (i2c_page == cscp_pkg::REG_PAGE);
		uc_here = (uc_addr[15:8] == cscp_pkg::UC_BASE_HI);
		i2c_acc = '{wr: i2c_wr, rd: i2c_rd, ofs: i2c_ofs, wdata: i2c_wdata};
		uc_acc = '{wr: uc_wr, rd: uc_rd, ofs: uc_addr[7:0], wdata: uc_wdata};
		i2c_dec = i2c_here ? decode(i2c_acc.ofs) : '0;
		uc_dec = uc_here ? decode(uc_acc.ofs) : '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// register pairs

	always_comb begin
		for (int b = 0; b < 2; b++) begin
			ctrl_next[b] = ctrl_reg[b];
			oper_next[b] = oper_reg[b];
			// the microcontroller write lands last and so wins a collision
			if (i2c_acc.wr && i2c_dec.hit && i2c_dec.idx == b[0]) begin
				if (i2c_dec.oper) begin
					oper_next[b] = (oper_reg[b] & ~cscp_pkg::OPER_WR_MASK)
						| (i2c_acc.wdata & cscp_pkg::OPER_WR_MASK);
				end else begin
					ctrl_next[b] = i2c_acc.wdata;
				end
			end
			if (uc_acc.wr && uc_dec.hit && uc_dec.idx == b[0]) begin
				if (uc_dec.oper) begin
					oper_next[b] = (oper_next[b] & ~cscp_pkg::OPER_WR_MASK)
						| (uc_acc.wdata & cscp_pkg::OPER_WR_MASK);
				end else begin
					ctrl_next[b] = uc_acc.wdata;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < 2; b++) begin
				ctrl_reg[b] <= cscp_pkg::CTRL_RESET;
				oper_reg[b] <= cscp_pkg::OPER_RESET;
			end
		end else begin
			for (int b = 0; b < 2; b++) begin
				ctrl_reg[b] <= ctrl_next[b];
				oper_reg[b] <= oper_next[b];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data

	logic [7:0] i2c_rdata_reg;
	logic [7:0] i2c_rdata_next;
	logic [7:0] uc_rdata_reg;
	logic [7:0] uc_rdata_next;

	always_comb begin
		i2c_rdata_next = i2c_rdata_reg;
		uc_rdata_next = uc_rdata_reg;
		if (i2c_acc.rd) begin
			i2c_rdata_next = read_byte(i2c_dec, ctrl_reg[0], ctrl_reg[1],
				oper_reg[0], oper_reg[1], latch_state);
		end
		if (uc_acc.rd) begin
			uc_rdata_next = read_byte(uc_dec, ctrl_reg[0], ctrl_reg[1],
				oper_reg[0], oper_reg[1], latch_state);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			i2c_rdata_reg <= 8'h00;
			uc_rdata_reg <= 8'h00;
		end else begin
			i2c_rdata_reg <= i2c_rdata_next;
			uc_rdata_reg <= uc_rdata_next;
		end
	end

	assign i2c_rdata = i2c_rdata_reg;
	assign uc_rdata = uc_rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// half-bridges

	for (genvar g = 0; g < 2; g++) begin : g_bridge
		cscp_bridge_guard u_guard (
			.clk(clk),
			.rst(rst),
			.short_sense(short_sense[g]),
			// a latch in the other half-bridge stops this one as well
			.enable(ctrl_reg[g][cscp_pkg::CTRL_EN_BIT] & ~latch_state[1 - g]),
			.protection_off(oper_reg[g][cscp_pkg::OPER_PROT_OFF_BIT]),
			.latch_clear(latch_clear),
			.pwm_timing(pwm_timing[g]),
			.gate_drive(gate_drive[g]),
			.fault(latch_state[g])
		);
		assign short_trip_level[g] =
			cscp_pkg::cscp_trip_t'(ctrl_reg[g][cscp_pkg::CTRL_TRIP_LSB +: 2]);
	end

	assign fault = latch_state;

	////////////////////////////////////////////////////////////////////////////////
	// switching rate watch on the first half-bridge timing

	localparam logic [cscp_pkg::PWM_CNT_W-1:0] CNT_LO =
		cscp_pkg::PWM_CNT_W'(cscp_pkg::PWM_MIN_CYC - cscp_pkg::PWM_SLACK_CYC);
	localparam logic [cscp_pkg::PWM_CNT_W-1:0] CNT_HI =
		cscp_pkg::PWM_CNT_W'(cscp_pkg::PWM_MAX_CYC + cscp_pkg::PWM_SLACK_CYC);
	localparam logic [cscp_pkg::PWM_CNT_W-1:0] CNT_TOP = 8'hFF;
	localparam logic [cscp_pkg::PWM_CNT_W-1:0] CNT_ONE = 8'h01;

	logic [cscp_pkg::PWM_CNT_W-1:0] period_reg;
	logic [cscp_pkg::PWM_CNT_W-1:0] period_next;
	logic pwm_last_reg;
	logic pwm_last_next;
	logic rate_ok_reg;
	logic rate_ok_next;
	logic pwm_rise;

	always_comb begin
		pwm_last_next = pwm_timing[0];
		pwm_rise = pwm_timing[0] & ~pwm_last_reg;
		period_next = (period_reg == CNT_TOP) ? CNT_TOP : period_reg + CNT_ONE;
		rate_ok_next = rate_ok_reg;
		if (pwm_rise) begin
			rate_ok_next = (period_reg >= CNT_LO) && (period_reg <= CNT_HI);
			period_next = CNT_ONE;
		end else if (period_reg > CNT_HI) begin
			rate_ok_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period_reg <= 8'h00;
			pwm_last_reg <= 1'b0;
			rate_ok_reg <= 1'b0;
		end else begin
			period_reg <= period_next;
			pwm_last_reg <= pwm_last_next;
			rate_ok_reg <= rate_ok_next;
		end
	end

	assign pwm_rate_ok = rate_ok_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ctrl_write_lands_a: assert property (
		i2c_wr && i2c_page == 8'h00 && i2c_ofs == 8'h8A && !uc_wr
		|=> ctrl_reg[0] == $past(i2c_wdata))
		else $error("control write at 0x8A lost");
	uc_oper_write_a: assert property (
		uc_wr && uc_addr == 16'hA08D && !(i2c_wr && i2c_page == 8'h00 && i2c_ofs == 8'h8D)
		|=> oper_reg[1] == ($past(uc_wdata) & 8'hCF))
		else $error("operation write at 0xA08D wrong");
	reserved_no_store_a: assert property (
		!(i2c_wr && i2c_dec.hit) && !(uc_wr && uc_dec.hit)
		|=> $stable(ctrl_reg[0]) && $stable(ctrl_reg[1])
			&& $stable(oper_reg[0]) && $stable(oper_reg[1]))
		else $error("register changed without a mapped write");
	fault_reads_back_a: assert property (
		uc_rd && uc_addr == 16'hA08B |=> uc_rdata[4] == $past(latch_state[0]))
		else $error("fault flag read wrong");
	rate_reject_a: assert property (
		pwm_rise && period_reg < CNT_LO |=> !pwm_rate_ok)
		else $error("short period accepted");
	trip_level_a: assert property (
		short_trip_level[1] == cscp_pkg::cscp_trip_t'(ctrl_reg[1][3:2]))
		else $error("trip level not from control bits");
	all_off_latched_a: assert property (
		|latch_state && !latch_clear |=> gate_drive == '0)
		else $error("transistor on while a half-bridge is latched");
	rate_accept_a: assert property (
		pwm_rise && period_reg >= CNT_LO && period_reg <= CNT_HI |=> pwm_rate_ok)
		else $error("in-band period rejected");
	oper_ro_bits_a: assert property (
		(oper_reg[0][5:4] | oper_reg[1][5:4]) == 2'h0)
		else $error("read-only operation bits were stored");

	rate_ok_c: cover property ($rose(pwm_rate_ok));
	fault_read_c: cover property (latch_state[0] ##1 i2c_rd && i2c_ofs == 8'h8B);
	both_latched_c: cover property (latch_state == 2'h3 ##[1:20] latch_state == 2'h0);

endmodule : cscp_top
